// ---- logic/fpsx_consts.svh ----
// Purpose: Constants for the FP SIMD exception status block
// Assumes: Included by the block, the properties and the bench
// Notes: Offsets are APB byte addresses
`ifndef FPSX_CONSTS_SVH
`define FPSX_CONSTS_SVH
`define FPSX_OFF_CTRL 12'h000
`define FPSX_OFF_XREG 12'h004
`define FPSX_OFF_STAT 12'h008
`define FPSX_OFF_TRAP 12'h00C
`define FPSX_OFF_ID 12'h010
`define FPSX_CTRL_NS 0
`define FPSX_XR_V 31
`define FPSX_XR_SIMD 28
`define FPSX_XR_URD 25
`define FPSX_XR_URS1 22
`define FPSX_XR_URS2 19
`define FPSX_XR_URS3 16
`define FPSX_ST_CUR 0
`define FPSX_ST_ACC 5
`define FPSX_ST_TEM 23
`define FPSX_NX_BIT 0
`define FPSX_SIMD_EXT 9'h100
`define FPSX_ID_VALUE 32'h0000_5A5A // Arbitrary identity value
`endif

// ---- logic/fpsx_pkg.sv ----
// Purpose: Types for the FP SIMD exception status block
// Assumes: Exception flag order nv,of,uf,dz,nx from bit 4 down
// Notes: Constants live in fpsx_consts.svh
package fpsx_pkg;
  typedef logic [4:0] fpsx_flags_t;
  typedef enum logic [1:0] {
    FPSX_TT_NONE = 2'b00,
    FPSX_TT_IEEE = 2'b01,
    FPSX_TT_INCOMPLETE = 2'b11,
    FPSX_TT_UNIMPL = 2'b10
  } fpsx_tt_e;
  typedef enum logic [2:0] {
    FPSX_OP_ARITH = 3'h0,
    FPSX_OP_DIV = 3'h1,
    FPSX_OP_SQRT = 3'h2,
    FPSX_OP_GFX_ARITH = 3'h3,
    FPSX_OP_CC = 3'h4,
    FPSX_OP_RCMOVE = 3'h5,
    FPSX_OP_FMA = 3'h6,
    FPSX_OP_GFX_LOGIC = 3'h7
  } fpsx_op_e;
  // One lane result from an execution lane
  typedef struct packed {
    logic ieee;
    logic other;
    logic subnormal;
    fpsx_flags_t flags;
    logic [63:0] data;
  } fpsx_lane_s;
  // Issue request from the pipeline
  typedef struct packed {
    logic valid;
    fpsx_op_e op;
    logic single;
    logic swap;
    logic [5:0] rd;
    logic [5:0] rs1;
    logic [5:0] rs2;
    logic [5:0] rs3;
  } fpsx_issue_s;
endpackage : fpsx_pkg

// ---- logic/fpsx_unit.sv ----
// Purpose: FP operand steering and exception status for scalar and SIMD ops
// Assumes: One pclk domain; lanes return results in the commit cycle
// Notes: Registers reached over APB; no interrupt output
//
// Summary of operation
// - Extension valid selects double-width single-precision registers
// - Double-width singles only address even registers
// - Double-width single operand read from bits 63:32, else 31:0
// - Double-width single result written high, low zeroed
// - Byte swap single words in 4-byte units
// - Valid plus SIMD flag runs two lanes
// - SIMD pairs f[2n],f[2n+256]; bad register traps
// - Fused multiply-add may name extended sources
// - Divide, sqrt, graphics arithmetic, cc, conditional move not SIMD
// - Basic writes f[2n], extended f[2n+256], swapped separately
// - Flush subnormal to signed zero, inexact trap
// - Flush flag clear gives full IEEE behaviour
// - Current flags bits 4:0, cleared without exception
// - Current flag update follows fixed priority
// - Mask, current, accrued flags all in hardware
// - Single lane exception acts like scalar
// - Both masked IEEE: no trap, OR both
// - Unmasked IEEE lanes trap, accrued unchanged
// - IEEE plus other gives incomplete trap
// - Scalar IEEE sets one flag, SIMD maybe two
// - Register number is 3 extension bits plus 6
`timescale 1ns/1ps
`include "fpsx_consts.svh"
module fpsx_unit
  import fpsx_pkg::*;
#(
  parameter int REG_NUM_W = 9
) (
  input wire logic pclk, // Core clock, 250 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire fpsx_issue_s issue, // Issue request
  input wire logic [63:0] src1_raw, // Register file read of src1
  input wire logic [63:0] src2_raw, // Register file read of src2
  output logic [REG_NUM_W-1:0] src1_num, // Full src1 register number
  output logic [REG_NUM_W-1:0] src2_num, // Full src2 register number
  output logic [REG_NUM_W-1:0] dst_num, // Full basic dest number
  output logic [REG_NUM_W-1:0] dst_ext_num, // Extended dest number
  output logic [31:0] op1_single, // Single operand 1
  output logic [31:0] op2_single, // Single operand 2
  output logic issue_simd, // Issue runs as two lanes
  output logic issue_double_regs, // Double-width regs, for singles or a two-lane issue
  output logic bad_operand_trap, // Under SIMD: bad register named, or non-SIMD op
  output logic flush_en, // Lanes flush subnormals
  input wire logic commit, // An FP op commits
  input wire fpsx_lane_s lane_basic, // Basic lane result
  input wire fpsx_lane_s lane_ext, // Extended lane result
  input wire logic load_commit, // Status load commits
  input wire logic [31:0] load_data, // Status load data
  output logic [63:0] wb_basic, // Basic write-back data
  output logic [63:0] wb_ext, // Extended write-back data
  output logic ieee_arith_trap, // IEEE trap pulse
  output logic other_type_trap, // Other trap pulse
  output logic [1:0] trap_type // Trap type with either trap pulse
);

  // Software visible state and per-issue commit state
  logic flush_subnormal_flag_reg;
  logic [31:0] register_extension_reg;
  fpsx_flags_t cur_flags_reg;
  fpsx_flags_t acc_flags_reg;
  fpsx_flags_t trap_enable_mask_reg;
  logic simd_commit_reg;
  logic sgl_commit_reg;
  logic swap_commit_reg;

  wire extension_valid_flag = register_extension_reg[`FPSX_XR_V];
  wire simd_flag = register_extension_reg[`FPSX_XR_SIMD];
  wire [2:0] urd_bits = register_extension_reg[`FPSX_XR_URD +: 3];
  wire [2:0] src1_upper_bits = register_extension_reg[`FPSX_XR_URS1 +: 3];
  wire [2:0] src2_upper_bits = register_extension_reg[`FPSX_XR_URS2 +: 3];
  wire inexact_trap_mask = trap_enable_mask_reg[`FPSX_NX_BIT];

  // Register number forming
  function automatic logic [8:0] fpsx_reg_num(input logic [2:0] up, input logic [5:0] f);
    fpsx_reg_num = {up, f[5:1], 1'b0};
  endfunction : fpsx_reg_num

  wire [8:0] n_s1 = fpsx_reg_num(src1_upper_bits, issue.rs1);
  wire [8:0] n_s2 = fpsx_reg_num(src2_upper_bits, issue.rs2);
  wire [8:0] n_d = fpsx_reg_num(urd_bits, issue.rd);

  // SIMD eligibility and operand checks
  wire simd_req = extension_valid_flag & simd_flag;
  wire op_no_simd = (issue.op == FPSX_OP_DIV) | (issue.op == FPSX_OP_SQRT) |
                    (issue.op == FPSX_OP_GFX_ARITH) | (issue.op == FPSX_OP_CC) |
                    (issue.op == FPSX_OP_RCMOVE);
  wire is_fma = issue.op == FPSX_OP_FMA;
  wire s1_ext = n_s1[8];
  wire s2_ext = n_s2[8];
  wire src_bad = (s1_ext | s2_ext) & ~is_fma;
  wire simd_bad = simd_req & (op_no_simd | src_bad | n_d[8]);
  wire simd_go = simd_req & ~simd_bad;
  wire dbl_regs = extension_valid_flag & issue.single;

  // Single operand extraction with optional per-word byte swap
  function automatic logic [31:0] fpsx_swap32(input logic [31:0] w);
    fpsx_swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : fpsx_swap32

  wire [31:0] s1_word = dbl_regs ? src1_raw[63:32] : src1_raw[31:0];
  wire [31:0] s2_word = dbl_regs ? src2_raw[63:32] : src2_raw[31:0];
  wire [31:0] op1_next = issue.swap ? fpsx_swap32(s1_word) : s1_word;
  wire [31:0] op2_next = issue.swap ? fpsx_swap32(s2_word) : s2_word;

  // Write-back formatting, each lane swapped on its own
  function automatic logic [63:0] fpsx_wb(input logic [63:0] d, input logic sgl, input logic sw);
    logic [31:0] hi;
    hi = sw ? fpsx_swap32(d[63:32]) : d[63:32];
    if (sgl) begin
      fpsx_wb = {hi, 32'h0000_0000};
    end else begin
      fpsx_wb = sw ? {hi, fpsx_swap32(d[31:0])} : d;
    end
  endfunction : fpsx_wb

  // Flush of subnormal lane results to signed zero
  wire [63:0] b_data = (flush_subnormal_flag_reg & lane_basic.subnormal) ?
                       {lane_basic.data[63], 63'h0} : lane_basic.data;
  wire [63:0] e_data = (flush_subnormal_flag_reg & lane_ext.subnormal) ?
                       {lane_ext.data[63], 63'h0} : lane_ext.data;

  // Lane exception classification; flushed subnormal becomes inexact
  wire b_flush = flush_subnormal_flag_reg & lane_basic.subnormal;
  wire e_flush = simd_commit_reg & flush_subnormal_flag_reg & lane_ext.subnormal;
  wire b_other = lane_basic.other & ~b_flush;
  wire e_other = simd_commit_reg & lane_ext.other & ~e_flush;
  wire [4:0] b_fl = b_flush ? 5'h01 : lane_basic.flags;
  wire [4:0] e_fl = e_flush ? 5'h01 : (simd_commit_reg ? lane_ext.flags : 5'h00);
  wire b_ieee = (lane_basic.ieee | b_flush) & ~b_other;
  wire e_ieee = simd_commit_reg & (lane_ext.ieee | e_flush) & ~e_other;
  wire any_other = b_other | e_other;
  wire any_ieee = b_ieee | e_ieee;
  wire [4:0] or_fl = b_fl | e_fl;
  wire unmasked = |(or_fl & trap_enable_mask_reg) | ((b_flush | e_flush) & inexact_trap_mask);
  wire is_ieee_commit = commit & ~any_other & any_ieee;

  // Current and accrued flag next values in priority order
  wire [4:0] cur_next = load_commit ? load_data[`FPSX_ST_CUR +: 5] :
                        (commit & ~any_other & ~any_ieee) ? or_fl :
                        is_ieee_commit ? or_fl : cur_flags_reg;
  wire [4:0] acc_next = load_commit ? load_data[`FPSX_ST_ACC +: 5] :
                        (commit & ~any_other & ~unmasked) ? (acc_flags_reg | or_fl) :
                        acc_flags_reg;

  // APB decode
  wire apb_wr = psel & penable & pwrite & ~pready;
  wire apb_rd = psel & penable & ~pwrite & ~pready;
  wire hit_ctrl = paddr == `FPSX_OFF_CTRL;
  wire hit_xreg = paddr == `FPSX_OFF_XREG;
  wire hit_stat = paddr == `FPSX_OFF_STAT;
  wire hit_trap = paddr == `FPSX_OFF_TRAP;
  wire hit_id = paddr == `FPSX_OFF_ID;
  wire hit_any = hit_ctrl | hit_xreg | hit_stat | hit_trap | hit_id;
  wire [31:0] stat_word = {4'h0, trap_enable_mask_reg, 13'h0000, acc_flags_reg, cur_flags_reg};
  wire [31:0] trap_word = {29'h0, simd_commit_reg, trap_type};
  wire [31:0] rd_word;
  assign rd_word = hit_ctrl ? {31'h0, flush_subnormal_flag_reg} :
                   hit_xreg ? register_extension_reg :
                   hit_stat ? stat_word :
                   hit_trap ? trap_word :
                   hit_id ? `FPSX_ID_VALUE : 32'h0000_0000;
  wire [31:0] xreg_wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] xreg_wr = (register_extension_reg & ~xreg_wmask) | (pwdata & xreg_wmask);
  wire status_sw_wr = apb_wr & hit_stat & pstrb[0];

  // APB response: one wait state, error on unmapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_any;
      prdata <= apb_rd ? rd_word : 32'h0000_0000;
    end
  end

  // Control and extension registers; extension cleared after a commit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_subnormal_flag_reg <= 1'b0;
      register_extension_reg <= 32'h0000_0000;
    end else begin
      if (apb_wr & hit_ctrl & pstrb[0]) begin
        flush_subnormal_flag_reg <= pwdata[`FPSX_CTRL_NS];
      end
      if (apb_wr & hit_xreg) begin
        register_extension_reg <= xreg_wr;
      end else if (commit | ieee_arith_trap | other_type_trap) begin
        register_extension_reg <= 32'h0000_0000;
      end
    end
  end

  // Trap decisions; other-type dominates an IEEE lane
  wire trap_other_next = commit & any_other;
  wire trap_ieee_next = is_ieee_commit & unmasked;
  wire [1:0] trap_type_next = trap_other_next ? FPSX_TT_INCOMPLETE :
                              trap_ieee_next ? FPSX_TT_IEEE : FPSX_TT_NONE;

  // Status word writes; a committing update in the same cycle wins
  wire sw_flags_wr = status_sw_wr & ~commit & ~load_commit;
  wire [4:0] tem_next = load_commit ? load_data[`FPSX_ST_TEM +: 5] :
                        status_sw_wr ? pwdata[`FPSX_ST_TEM +: 5] : trap_enable_mask_reg;

  // Current exception flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_flags_reg <= 5'h00;
    end else if (sw_flags_wr) begin
      cur_flags_reg <= pwdata[`FPSX_ST_CUR +: 5];
    end else begin
      cur_flags_reg <= cur_next;
    end
  end

  // Accrued exception flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_flags_reg <= 5'h00;
    end else if (sw_flags_wr) begin
      acc_flags_reg <= pwdata[`FPSX_ST_ACC +: 5];
    end else begin
      acc_flags_reg <= acc_next;
    end
  end

  // Trap enable mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_enable_mask_reg <= 5'h00;
    end else begin
      trap_enable_mask_reg <= tem_next;
    end
  end

  // Trap pulses, one cycle after the commit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ieee_arith_trap <= 1'b0;
      other_type_trap <= 1'b0;
      trap_type <= FPSX_TT_NONE;
    end else begin
      ieee_arith_trap <= trap_ieee_next;
      other_type_trap <= trap_other_next;
      trap_type <= trap_type_next;
    end
  end

  // Per-issue state kept until that operation commits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      simd_commit_reg <= 1'b0;
      sgl_commit_reg <= 1'b0;
      swap_commit_reg <= 1'b0;
    end else if (issue.valid) begin
      simd_commit_reg <= simd_go;
      sgl_commit_reg <= dbl_regs;
      swap_commit_reg <= issue.swap;
    end
  end

  // Full register numbers of the issued instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src1_num <= '0;
      src2_num <= '0;
      dst_num <= '0;
      dst_ext_num <= '0;
    end else begin
      src1_num <= REG_NUM_W'(n_s1);
      src2_num <= REG_NUM_W'(n_s2);
      dst_num <= REG_NUM_W'(n_d);
      dst_ext_num <= REG_NUM_W'(n_d | `FPSX_SIMD_EXT);
    end
  end

  // Single-precision operands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op1_single <= 32'h0000_0000;
      op2_single <= 32'h0000_0000;
    end else begin
      op1_single <= op1_next;
      op2_single <= op2_next;
    end
  end

  // Issue decisions, one pulse per valid issue; flush_en follows the flush flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      issue_simd <= 1'b0;
      issue_double_regs <= 1'b0;
      bad_operand_trap <= 1'b0;
      flush_en <= 1'b0;
    end else begin
      issue_simd <= issue.valid & simd_go;
      issue_double_regs <= issue.valid & (dbl_regs | simd_go);
      bad_operand_trap <= issue.valid & simd_bad;
      flush_en <= flush_subnormal_flag_reg;
    end
  end

  // Write-back data per lane, formatted as latched at issue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_basic <= 64'h0000_0000_0000_0000;
      wb_ext <= 64'h0000_0000_0000_0000;
    end else begin
      wb_basic <= fpsx_wb(b_data, sgl_commit_reg, swap_commit_reg);
      wb_ext <= fpsx_wb(e_data, sgl_commit_reg, swap_commit_reg);
    end
  end

endmodule : fpsx_unit

// ---- sim/fpsx_unit_properties.sv ----
// Purpose: Concurrent checks on the fpsx_unit ports
// Assumes: Bound to fpsx_unit from the bench top file
// Notes: One pclk domain, async active-low reset
`timescale 1ns/1ps
`include "fpsx_consts.svh"
module fpsx_unit_properties
  import fpsx_pkg::*;
#(
  parameter int REG_NUM_W = 9
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire fpsx_issue_s issue, // Issue request
  input wire logic commit, // Commit pulse
  input wire fpsx_lane_s lane_basic, // Basic lane result
  input wire logic [REG_NUM_W-1:0] src1_num, // Src1 number
  input wire logic [REG_NUM_W-1:0] dst_num, // Basic dest number
  input wire logic [REG_NUM_W-1:0] dst_ext_num, // Extended dest number
  input wire logic issue_simd, // Two-lane issue
  input wire logic issue_double_regs, // Double-width singles
  input wire logic ieee_arith_trap, // IEEE trap pulse
  input wire logic other_type_trap, // Other trap pulse
  input wire logic [1:0] trap_type // Trap type
);
  logic [4:0] rs1_q;
  // Field of the last issue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rs1_q <= '0;
    else rs1_q <= issue.rs1[5:1];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_src_number: assert property (issue.valid |=> src1_num[5:0] == {rs1_q, 1'b0})
    else $error("src1 number not built from field");
  a_ext_dest: assert property (issue_simd |-> dst_ext_num == (dst_num | `FPSX_SIMD_EXT))
    else $error("extended dest not paired");
  a_simd_excluded: assert property (issue.valid && issue.op inside {FPSX_OP_DIV, FPSX_OP_SQRT,
    FPSX_OP_GFX_ARITH, FPSX_OP_CC, FPSX_OP_RCMOVE} |=> !issue_simd)
    else $error("excluded op issued as two lanes");
  a_simd_double: assert property (issue_simd |-> issue_double_regs)
    else $error("two-lane issue without double regs");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  a_trap_excl: assert property (ieee_arith_trap |-> !other_type_trap)
    else $error("both trap kinds at once");
  a_trap_cause: assert property (ieee_arith_trap || other_type_trap |-> $past(commit))
    else $error("trap without commit");
  a_other_kind: assert property (commit && lane_basic.other && !lane_basic.subnormal |=>
    other_type_trap && trap_type == FPSX_TT_INCOMPLETE)
    else $error("other lane result not incomplete trap");
  c_simd_issue: cover property (issue_simd);
  c_other_trap: cover property (other_type_trap);
  c_ieee_trap: cover property (ieee_arith_trap);
endmodule : fpsx_unit_properties

// ---- sim/fpsx_lane_model.sv ----
// Purpose: Execution lane model that commits after a set delay
// Assumes: Bench loads outcomes and pulses req
// Notes: Lane buses toggle outside the commit cycle
`timescale 1ns/1ps
module fpsx_lane_model
  import fpsx_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic req, // Start one operation
  input wire logic [3:0] dly, // Cycles before commit
  input wire fpsx_lane_s b_in, // Basic lane outcome
  input wire fpsx_lane_s e_in, // Extended lane outcome
  output logic commit, // Commit pulse
  output fpsx_lane_s lane_basic, // Basic lane result
  output fpsx_lane_s lane_ext // Extended lane result
);
  logic busy;
  logic [3:0] cnt;
  initial begin
    commit = 0;
    busy = 0;
    cnt = 0;
    lane_basic = '0;
    lane_ext = '0;
  end
  // Lane results only hold meaning in the commit cycle
  always @(posedge pclk) begin
    commit <= 0;
    lane_basic <= ~lane_basic;
    lane_ext <= ~lane_ext;
    if (req) begin
      busy <= 1;
      cnt <= dly;
    end else if (busy && cnt == 0) begin
      busy <= 0;
      commit <= 1;
      lane_basic <= b_in;
      lane_ext <= e_in;
    end else if (busy) begin
      cnt <= cnt - 1;
    end
  end
endmodule : fpsx_lane_model

// ---- sim/fpsx_unit_tb.sv ----
// Purpose: Self-checking bench for fpsx_unit
// Assumes: APB slave with one wait state
// Notes: Lane model answers promptly or slowly
`timescale 1ns/1ps
`include "fpsx_consts.svh"
module fpsx_unit_tb
  import fpsx_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, load_commit = 0, req = 0;
  logic pready, pslverr, commit, issue_simd, issue_double_regs, bad_operand_trap, flush_en, rde;
  logic ieee_arith_trap, other_type_trap;
  logic [1:0] trap_type;
  logic [3:0] pstrb = 4'hF, dly = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, load_data = '0, prdata, op1_single, op2_single, rdv;
  logic [63:0] src1_raw = 64'h1122_3344_5566_7788, src2_raw = 64'hA1B2_C3D4_E5F6_0718, wb_basic, wb_ext;
  logic [8:0] src1_num, src2_num, dst_num, dst_ext_num;
  fpsx_issue_s issue = '0;
  fpsx_lane_s lane_basic, lane_ext, mb = '0, me = '0;
  fpsx_op_e nos[5] = '{FPSX_OP_DIV, FPSX_OP_SQRT, FPSX_OP_GFX_ARITH, FPSX_OP_CC, FPSX_OP_RCMOVE};
  int n_mismatch = 0, cmp_count = 0;
  always #2 pclk = ~pclk;
  fpsx_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .issue, .src1_raw, .src2_raw, .src1_num, .src2_num, .dst_num, .dst_ext_num, .op1_single,
    .op2_single, .issue_simd, .issue_double_regs, .bad_operand_trap, .flush_en, .commit, .lane_basic,
    .lane_ext, .load_commit, .load_data, .wb_basic, .wb_ext, .ieee_arith_trap, .other_type_trap, .trap_type);
  fpsx_lane_model u_lane (.pclk, .req, .dly, .b_in(mb), .e_in(me), .commit, .lane_basic, .lane_ext);
  task results;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task tmo(input int i);
    if (i == 16) begin
      n_mismatch++;
      results();
    end
  endtask : tmo
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    tmo(i);
    rdv = prdata;
    rde = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task iss(input fpsx_op_e o, input logic [5:0] s1, input logic sw = 1'b0);
    @(posedge pclk);
    issue <= '{1'b1, o, 1'b1, sw, 6'h04, s1, 6'h02, 6'h00};
    @(posedge pclk);
    issue.valid <= 0;
    #1;
  endtask : iss
  function automatic fpsx_lane_s ln(input logic i, input logic o, input fpsx_flags_t f, input logic s = 1'b0,
    input logic [63:0] d = 64'h0);
    return '{i, o, s, f, d};
  endfunction : ln
  task run(input logic [31:0] xr, input fpsx_lane_s b, input fpsx_lane_s e, input logic [3:0] d,
    input logic sw = 1'b0);
    int i;
    apb(1, `FPSX_OFF_XREG, xr);
    iss(FPSX_OP_ARITH, 6'h02, sw);
    mb <= b;
    me <= e;
    dly <= d;
    req <= 1;
    @(posedge pclk);
    req <= 0;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (commit === 1'b1) break;
    end
    tmo(i);
    #1;
  endtask : run
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, `FPSX_OFF_ID, 0);
    chk("id", `FPSX_ID_VALUE, rdv);
    apb(0, 12'h020, 0);
    chk("unmapped err", 1, rde);
    apb(1, `FPSX_OFF_STAT, 32'h0F80_03FF);
    apb(0, `FPSX_OFF_STAT, 0);
    chk("stat rw", 32'h0F80_03FF, rdv);
    apb(1, `FPSX_OFF_STAT, 0);
    $display("test registers done");
    run(0, ln(1, 0, 5'h04), ln(0, 0, 5'h00), 0);
    chk("scalar trap", 0, ieee_arith_trap);
    apb(0, `FPSX_OFF_STAT, 0);
    chk("scalar flags", 32'h0000_0084, rdv);
    run(0, ln(0, 0, 5'h00), ln(0, 0, 5'h00), 3);
    apb(0, `FPSX_OFF_STAT, 0);
    chk("cleared flags", 32'h0000_0080, rdv);
    run(32'h9000_0000, ln(1, 0, 5'h01), ln(1, 0, 5'h10), 5);
    chk("masked trap", 0, ieee_arith_trap);
    apb(0, `FPSX_OFF_STAT, 0);
    chk("masked flags", 32'h0000_02B1, rdv);
    apb(1, `FPSX_OFF_STAT, 32'h0080_0000);
    run(32'h9000_0000, ln(1, 0, 5'h02), ln(1, 0, 5'h01), 0);
    chk("unmasked trap", 1, ieee_arith_trap);
    chk("ieee type", FPSX_TT_IEEE, trap_type);
    apb(0, `FPSX_OFF_STAT, 0);
    chk("unmasked flags", 32'h0080_0003, rdv);
    run(32'h9000_0000, ln(0, 1, 5'h00), ln(1, 0, 5'h08), 2);
    chk("other trap", 1, other_type_trap);
    chk("other type", FPSX_TT_INCOMPLETE, trap_type);
    apb(0, `FPSX_OFF_STAT, 0);
    chk("other flags", 32'h0080_0003, rdv);
    @(posedge pclk);
    load_commit <= 1;
    load_data <= 32'h0000_0010;
    @(posedge pclk);
    load_commit <= 0;
    apb(0, `FPSX_OFF_STAT, 0);
    chk("load flags", 32'h0000_0010, rdv);
    $display("test flags done");
    apb(1, `FPSX_OFF_XREG, 32'h9680_0000);
    iss(FPSX_OP_ARITH, 6'h0B);
    chk("src1 num", 9'h08A, src1_num);
    chk("dst num", 9'h0C4, dst_num);
    chk("dst ext", 9'h1C4, dst_ext_num);
    chk("op1 high", 32'h1122_3344, op1_single);
    chk("op2 high", 32'hA1B2_C3D4, op2_single);
    chk("src2 num", 9'h002, src2_num);
    chk("simd", 1, issue_simd);
    chk("double regs", 1, issue_double_regs);
    chk("no bad", 0, bad_operand_trap);
    foreach (nos[k]) begin
      iss(nos[k], 6'h02);
      chk("not simd", 0, issue_simd);
    end
    apb(1, `FPSX_OFF_XREG, 32'h9100_0000);
    iss(FPSX_OP_FMA, 6'h02);
    chk("fma ext src", 0, bad_operand_trap);
    iss(FPSX_OP_ARITH, 6'h02);
    chk("bad src", 1, bad_operand_trap);
    apb(1, `FPSX_OFF_CTRL, 1);
    #1;
    chk("flush on", 1, flush_en);
    apb(1, `FPSX_OFF_STAT, 32'h0080_0000);
    run(32'h9000_0000, ln(0, 0, 5'h00, 0, 64'h1122_3344_5566_7788),
      ln(0, 0, 5'h00, 1, 64'h8000_0000_0000_0001), 1, 1);
    chk("flush trap", 1, ieee_arith_trap);
    chk("wb basic", 64'h4433_2211_0000_0000, wb_basic);
    chk("wb ext", 64'h0000_0080_0000_0000, wb_ext);
    apb(0, `FPSX_OFF_STAT, 0);
    chk("flush flags", 32'h0080_0001, rdv);
    apb(1, `FPSX_OFF_CTRL, 0);
    #1;
    chk("flush off", 0, flush_en);
    $display("test issue done");
    results();
  end
endmodule : fpsx_unit_tb
bind fpsx_unit fpsx_unit_properties #(.REG_NUM_W(REG_NUM_W)) u_props (.pclk, .presetn, .psel, .penable,
  .pready, .issue, .commit, .lane_basic, .src1_num, .dst_num, .dst_ext_num, .issue_simd, .issue_double_regs,
  .ieee_arith_trap, .other_type_trap, .trap_type);
